//--- logic/cbd_pkg.sv
// constants shared by the cell balancing and wire diagnostic block
package cbd_pkg;
  localparam int NUM_CELLS = 12;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BAL_EN = 8'h04;
  localparam logic [7:0] OFF_COMM_WATCHDOG = 8'h08;
  localparam logic [7:0] OFF_TTHR_LO = 8'h0C;
  localparam logic [7:0] OFF_TTHR_HI = 8'h10;
  localparam logic [7:0] OFF_OL_THR = 8'h14;
  localparam logic [7:0] OFF_CUR_THR = 8'h18;
  localparam logic [7:0] OFF_OT_THR = 8'h1C;
  localparam logic [7:0] OFF_OL_RES = 8'h20;
  localparam logic [7:0] OFF_OC_RES = 8'h24;
  localparam logic [7:0] OFF_UC_RES = 8'h28;
  localparam logic [7:0] OFF_GENERAL_DIAG_REG = 8'h2C;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  // control register field positions
  localparam int CTRL_PAUSE = 0;
  localparam int CTRL_EXTENDED_WATCHDOG_ENABLE = 1;
  localparam int CTRL_DIAG_FORCE = 2;
  localparam int CTRL_DUTY_LSB = 4;
  localparam int CTRL_MASK_LSB = 16;
  // general diagnostic bit positions
  localparam int GD_OL = 0;
  localparam int GD_OC = 1;
  localparam int GD_UC = 2;
  localparam int GD_OT = 3;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0080;
  localparam logic [31:0] OL_THR_RST = 32'h0000_0000;
  localparam logic [31:0] CUR_THR_RST = 32'h0000_0000;
  localparam logic [9:0] OT_THR_RST = 10'h3FF;
  localparam logic [3:0] DUTY_FULL = 4'h8;
  // balancing timer step, 7.54 min, counted at 5 ns
  localparam longint CLK_PERIOD_PS = 5000;
  localparam longint BAL_STEP_MS = 452400;
  localparam longint BAL_STEP_CYCLES = (BAL_STEP_MS * 1000000000) / CLK_PERIOD_PS;
  localparam logic [4:0] TCOUNT_MAX = 5'h1F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- logic/cbd_cell_balance.sv
// cell balancing switch control with open-load and balancing current diagnostics
//
// Contract
// [R01] every cell balances independently, any combination
// [R02] per-cell enable bit requests balancing
// [R03] pause bit halts balancing during measurements
// [R04] pause also covers long-running measurement mode
// [R05] cell balances until counter reaches threshold
// [R06] threshold is 5 bits, 7.54 minute steps
// [R07] watchdog write starts timer when extended enabled
// [R08] pwm period is round robin, eighth steps
// [R09] host sets pwm by register writes
// [R10] switch closed on-phase, open off-phase
// [R11] measurement and diagnostics override pwm
// [R12] open-load test odd then even channels
// [R13] open-load flagged outside low/high window
// [R14] open-load thresholds programmable by register
// [R15] open-load sets channel bit and summary
// [R16] zero thresholds suppress that side
// [R17] balancing current checked for balancing cells
// [R18] current error stops balancing, records result
// [R19] force bit draws diag current everywhere configured
// [R20] internal overtemperature stops balancing, sets flag
// [R21] clearing enable opens switch next edge
`timescale 1ns/10ps
module cbd_cell_balance
  import cbd_pkg::*;
#(
  parameter logic [39:0] STEP_CYCLES = 40'(cbd_pkg::BAL_STEP_CYCLES)
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic primary_cell_volt_meas,
  input wire logic secondary_cell_volt_meas,
  input wire logic block_volt_meas,
  input wire logic rr_tick,
  input wire logic rr_diag_active,
  input wire logic ol_valid,
  input wire logic [3:0] ol_cell,
  input wire logic signed [9:0] ol_drop,
  input wire logic cur_valid,
  input wire logic [3:0] cur_cell,
  input wire logic [7:0] cur_value,
  input wire logic temp_valid,
  input wire logic [9:0] int_temp,
  output logic [cbd_pkg::NUM_CELLS-1:0] cell_gate_pin,
  output logic [cbd_pkg::NUM_CELLS-1:0] open_load_diag_current,
  output logic int_overtemp_warn
);
  localparam int N = NUM_CELLS;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] ctrl;
    logic [N-1:0] bal_en;
    logic [29:0] tthr_lo;
    logic [29:0] tthr_hi;
    logic [31:0] ol_thr;
    logic [31:0] cur_thr;
    logic [9:0] ot_thr;
    logic [N-1:0] ol_res;
    logic [N-1:0] oc_res;
    logic [N-1:0] uc_res;
    logic [3:0] general_diag_reg;
    logic timer_run;
    logic [4:0] tcount;
    logic [39:0] presc;
    logic [23:0] rr_cnt;
    logic [23:0] rr_period;
    logic rr_odd;
    logic [N-1:0] gate;
    logic [N-1:0] diagc;
  } cbd_state_t;

  cbd_state_t st_r;
  cbd_state_t st_nxt;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] cbd_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[8*b +: 8] = wd[8*b +: 8];
    end
    return res;
  endfunction

  // 5-bit time threshold of one cell
  function automatic logic [4:0] cbd_tthr(input logic [29:0] lo, input logic [29:0] hi,
                                          input int c);
    logic [4:0] v;
    if (c < 6)
      v = lo[5*c +: 5];
    else
      v = hi[5*(c-6) +: 5];
    return v;
  endfunction

  logic meas_busy;
  logic pwm_on;
  logic [3:0] duty;
  logic [26:0] pwm_pos;
  logic [27:0] pwm_lim;
  logic w_fire;
  logic [31:0] w_val;
  logic [N-1:0] bal_ok;
  logic [N-1:0] odd_sel;
  logic signed [10:0] drop_x;

  always_comb
  begin
    st_nxt = st_r;
    w_val = '0;
    bal_ok = '0;
    odd_sel = '0;
    drop_x = '0;
    duty = st_r.ctrl[CTRL_DUTY_LSB +: 4];
    meas_busy = primary_cell_volt_meas | secondary_cell_volt_meas | block_volt_meas;

    // write channel: address and data taken in either order, answer once both held
    if (s_axi_awvalid && st_r.awready)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && st_r.wready)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    w_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;

    // flag clears first so that hardware sets later in this process win
    if (w_fire)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      unique case (st_r.awaddr)
        OFF_CTRL: st_nxt.ctrl = cbd_merge(st_r.ctrl, st_r.wdata, st_r.wstrb); // [R09]
        OFF_BAL_EN:
        begin
          w_val = cbd_merge({20'h0_0000, st_r.bal_en}, st_r.wdata, st_r.wstrb);
          st_nxt.bal_en = w_val[N-1:0]; // [R02]
        end
        OFF_COMM_WATCHDOG:
        begin
          // restart the timed balancing interval
          if (st_r.ctrl[CTRL_EXTENDED_WATCHDOG_ENABLE])
          begin
            st_nxt.timer_run = 1'b1; // [R07]
            st_nxt.tcount = '0;
            st_nxt.presc = '0;
          end
        end
        OFF_TTHR_LO:
        begin
          w_val = cbd_merge({2'h0, st_r.tthr_lo}, st_r.wdata, st_r.wstrb);
          st_nxt.tthr_lo = w_val[29:0]; // [R06]
        end
        OFF_TTHR_HI:
        begin
          w_val = cbd_merge({2'h0, st_r.tthr_hi}, st_r.wdata, st_r.wstrb);
          st_nxt.tthr_hi = w_val[29:0];
        end
        OFF_OL_THR: st_nxt.ol_thr = cbd_merge(st_r.ol_thr, st_r.wdata, st_r.wstrb); // [R14]
        OFF_CUR_THR: st_nxt.cur_thr = cbd_merge(st_r.cur_thr, st_r.wdata, st_r.wstrb);
        OFF_OT_THR:
        begin
          w_val = cbd_merge({22'h00_0000, st_r.ot_thr}, st_r.wdata, st_r.wstrb);
          st_nxt.ot_thr = w_val[9:0];
        end
        // result registers clear by writing ones
        OFF_OL_RES: st_nxt.ol_res = st_r.ol_res & ~st_r.wdata[N-1:0];
        OFF_OC_RES: st_nxt.oc_res = st_r.oc_res & ~st_r.wdata[N-1:0];
        OFF_UC_RES: st_nxt.uc_res = st_r.uc_res & ~st_r.wdata[N-1:0];
        OFF_GENERAL_DIAG_REG: st_nxt.general_diag_reg = st_r.general_diag_reg & ~st_r.wdata[3:0];
        OFF_STATUS: st_nxt.bresp = RESP_OKAY;
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
    end
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;

    // read channel: one outstanding read, data registered with the answer
    if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && st_r.arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      unique case (s_axi_araddr[7:0])
        OFF_CTRL: st_nxt.rdata = st_r.ctrl;
        OFF_BAL_EN: st_nxt.rdata = {20'h0_0000, st_r.bal_en};
        OFF_COMM_WATCHDOG: st_nxt.rdata = {27'h000_0000, st_r.tcount};
        OFF_TTHR_LO: st_nxt.rdata = {2'h0, st_r.tthr_lo};
        OFF_TTHR_HI: st_nxt.rdata = {2'h0, st_r.tthr_hi};
        OFF_OL_THR: st_nxt.rdata = st_r.ol_thr;
        OFF_CUR_THR: st_nxt.rdata = st_r.cur_thr;
        OFF_OT_THR: st_nxt.rdata = {22'h00_0000, st_r.ot_thr};
        OFF_OL_RES: st_nxt.rdata = {20'h0_0000, st_r.ol_res};
        OFF_OC_RES: st_nxt.rdata = {20'h0_0000, st_r.oc_res};
        OFF_UC_RES: st_nxt.rdata = {20'h0_0000, st_r.uc_res};
        OFF_GENERAL_DIAG_REG: st_nxt.rdata = {28'h000_0000, st_r.general_diag_reg};
        OFF_STATUS: st_nxt.rdata = {3'h0, st_r.rr_odd, st_r.diagc, 4'h0, st_r.gate};
        default:
        begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    st_nxt.arready = !st_nxt.rvalid;

    // shared balancing counter, one count per 7.54 min step, stops at full scale
    if (st_r.timer_run && !(w_fire && st_r.awaddr == OFF_COMM_WATCHDOG))
    begin
      if (st_r.presc >= STEP_CYCLES - 40'h00_0000_0001)
      begin
        st_nxt.presc = '0;
        if (st_r.tcount != TCOUNT_MAX)
          st_nxt.tcount = st_r.tcount + 5'h01; // [R05]
      end
      else
        st_nxt.presc = st_r.presc + 40'h00_0000_0001;
    end

    // round robin period measured between ticks; parity picks odd or even wires
    if (rr_tick)
    begin
      st_nxt.rr_period = st_r.rr_cnt + 24'h00_0001;
      st_nxt.rr_cnt = '0;
      st_nxt.rr_odd = !st_r.rr_odd; // [R12]
    end
    else if (st_r.rr_cnt != 24'hFF_FFFF)
      st_nxt.rr_cnt = st_r.rr_cnt + 24'h00_0001;

    // on-phase while 8*position < duty*period; full duty needs no period yet
    pwm_pos = {st_r.rr_cnt, 3'b000};
    // both factors widened first so the product keeps all its bits
    pwm_lim = 28'(duty) * 28'(st_r.rr_period);
    pwm_on = (duty >= DUTY_FULL) || ({1'b0, pwm_pos} < pwm_lim); // [R08]

    // open-load window check; a zero threshold disables its side
    // sign-extend so a rising cell voltage stays negative against the window
    drop_x = {ol_drop[9], ol_drop};
    if (ol_valid && ol_cell < 4'(N))
    begin
      if ((st_r.ol_thr[5:0] != 6'h00 && drop_x < $signed({5'h00, st_r.ol_thr[5:0]})) ||
          (st_r.ol_thr[21:16] != 6'h00 && drop_x > $signed({5'h00, st_r.ol_thr[21:16]})))
      begin // [R13] [R16]
        st_nxt.ol_res[ol_cell] = 1'b1; // [R15]
        st_nxt.general_diag_reg[GD_OL] = 1'b1;
      end
    end

    // balancing current only judged on a cell that is really balancing
    if (cur_valid && cur_cell < 4'(N) && st_r.gate[cur_cell] && !st_r.diagc[cur_cell])
    begin // [R17]
      if (cur_value > st_r.cur_thr[7:0])
      begin
        st_nxt.oc_res[cur_cell] = 1'b1; // [R18]
        st_nxt.general_diag_reg[GD_OC] = 1'b1;
      end
      if (cur_value < st_r.cur_thr[23:16])
      begin
        st_nxt.uc_res[cur_cell] = 1'b1;
        st_nxt.general_diag_reg[GD_UC] = 1'b1;
      end
    end

    // internal overtemperature: warning holds off all balancing until cleared
    if (temp_valid && int_temp >= st_r.ot_thr)
      st_nxt.general_diag_reg[GD_OT] = 1'b1; // [R20]

    // per-cell switch decision, built from next-state enables so a clear acts at once
    for (int c = 0; c < N; c++)
    begin
      bal_ok[c] = st_nxt.bal_en[c] && !st_nxt.oc_res[c] && !st_nxt.uc_res[c] && // [R01] [R21]
                  (!st_r.ctrl[CTRL_EXTENDED_WATCHDOG_ENABLE] || !st_r.timer_run ||
                   st_r.tcount < cbd_tthr(st_r.tthr_lo, st_r.tthr_hi, c)); // [R05]
      odd_sel[c] = (c % 2 == 0) ? st_r.rr_odd : !st_r.rr_odd;
    end
    if (st_r.ctrl[CTRL_DIAG_FORCE])
    begin
      // forced diag current ignores enables and round robin timing
      st_nxt.diagc = st_r.ctrl[CTRL_MASK_LSB +: N]; // [R19]
      st_nxt.gate = '0;
    end
    else if (st_r.ctrl[CTRL_PAUSE] && meas_busy)
    begin
      // measurement input covers delay and conversion, also in long-running mode
      st_nxt.diagc = '0;
      st_nxt.gate = '0; // [R03] [R04] [R11]
    end
    else if (rr_diag_active)
    begin
      st_nxt.diagc = odd_sel; // [R12] [R11]
      st_nxt.gate = '0;
    end
    else
    begin
      st_nxt.diagc = '0;
      st_nxt.gate = (pwm_on && !st_nxt.general_diag_reg[GD_OT]) ? bal_ok : '0; // [R10] [R20]
    end
  end

  // single state register; synchronous active-low reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
      st_r.ctrl <= CTRL_RST;
      st_r.ol_thr <= OL_THR_RST;
      st_r.cur_thr <= CUR_THR_RST;
      st_r.ot_thr <= OT_THR_RST;
    end
    else
      st_r <= st_nxt;
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;
  assign cell_gate_pin = st_r.gate;
  assign open_load_diag_current = st_r.diagc;
  assign int_overtemp_warn = st_r.general_diag_reg[GD_OT];
endmodule

//--- verification/cbd_checker_props.sv
// port-level assertions for the cell balancing block
`timescale 1ns/10ps
module cbd_checker
  import cbd_pkg::*;
#(
  parameter logic [39:0] STEP_CYCLES = 40'h14
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic primary_cell_volt_meas,
  input wire logic secondary_cell_volt_meas,
  input wire logic block_volt_meas,
  input wire logic temp_valid,
  input wire logic [9:0] int_temp,
  input wire logic [cbd_pkg::NUM_CELLS-1:0] cell_gate_pin,
  input wire logic [cbd_pkg::NUM_CELLS-1:0] open_load_diag_current,
  input wire logic int_overtemp_warn
);
  import cbd_pkg::*;
  logic hs;
  logic meas;
  logic hs_ctrl;
  logic [2:0] ctrl_w;
  logic [2:0] ctrl_r;
  // both write halves taken at one edge, as the bench offers them
  assign hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign meas = primary_cell_volt_meas || secondary_cell_volt_meas || block_volt_meas;
  // shadow of low control bits, applied one edge after taking, as the block does
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hs_ctrl <= 1'b0;
      ctrl_w <= 3'h0;
      ctrl_r <= 3'h0;
    end
    else
    begin
      hs_ctrl <= hs && s_axi_awaddr[7:0] == OFF_CTRL && s_axi_wstrb[0];
      ctrl_w <= s_axi_wdata[2:0];
      if (hs_ctrl)
        ctrl_r <= ctrl_w;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_write_answer: assert property (hs |-> ##2 s_axi_bvalid) else $error("late write answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read answer");
  a_overtemp_flag: assert property (temp_valid && int_temp == 10'h3FF
    |-> ##[1:2] int_overtemp_warn) else $error("overtemp not flagged");
  a_pause_meas: assert property (ctrl_r[0] && meas |=> cell_gate_pin == '0)
    else $error("balancing during measurement");
  a_diag_odd_even: assert property (!ctrl_r[2] && !$past(ctrl_r[2], 3) |->
    (open_load_diag_current & 12'hAAA) == '0 || (open_load_diag_current & 12'h555) == '0)
    else $error("odd and even diag together");
  a_clear_opens: assert property (hs && s_axi_awaddr[7:0] == OFF_BAL_EN
    && s_axi_wstrb == 4'hF |-> ##2 (cell_gate_pin & ~$past(s_axi_wdata[11:0], 2)) == '0)
    else $error("switch left closed");
endmodule
bind cbd_cell_balance cbd_checker #(.STEP_CYCLES(STEP_CYCLES)) chk (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .primary_cell_volt_meas,
  .secondary_cell_volt_meas, .block_volt_meas, .temp_valid, .int_temp, .cell_gate_pin,
  .open_load_diag_current, .int_overtemp_warn);

//--- verification/cbd_rr_model.sv
// round robin sequencer standing in for the cell stack diagnostics
`timescale 1ns/10ps
module cbd_rr_model #(
  parameter int PERIOD = 16
)(
  input wire logic aclk,
  input wire logic run,
  input wire logic diag_on,
  output logic rr_tick,
  output logic rr_diag_active
);
  int cnt = 0;
  initial rr_tick = 1'b0;
  initial rr_diag_active = 1'b0;
  // tick opens each cycle, diag phase follows for four clocks
  always @(posedge aclk)
  begin
    cnt <= (!run || cnt == PERIOD - 1) ? 0 : cnt + 1;
    rr_tick <= run && cnt == PERIOD - 1;
    rr_diag_active <= run && diag_on && cnt < 4;
  end
endmodule

//--- verification/testbench.sv
// self-checking bench for the cell balancing block
`timescale 1ns/10ps
module testbench;
  import cbd_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [31:0] s_axi_awaddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [31:0] s_axi_araddr = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0;
  logic s_axi_wvalid = 0;
  logic s_axi_arvalid = 0;
  logic s_axi_bready = 1;
  logic s_axi_rready = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic primary_cell_volt_meas = 0;
  logic secondary_cell_volt_meas = 0;
  logic block_volt_meas = 0;
  logic rr_tick, rr_diag_active, int_overtemp_warn;
  logic ol_valid = 0;
  logic cur_valid = 0;
  logic temp_valid = 0;
  logic [3:0] ol_cell = 0;
  logic [3:0] cur_cell = 0;
  logic signed [9:0] ol_drop = 0;
  logic [7:0] cur_value = 0;
  logic [9:0] int_temp = 0;
  logic [11:0] cell_gate_pin, open_load_diag_current;
  logic run = 0;
  logic diag_on = 0;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // short timer step keeps the balancing intervals in reach
  cbd_cell_balance #(.STEP_CYCLES(40'h14)) uut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .primary_cell_volt_meas, .secondary_cell_volt_meas, .block_volt_meas, .rr_tick,
    .rr_diag_active, .ol_valid, .ol_cell, .ol_drop, .cur_valid, .cur_cell, .cur_value,
    .temp_valid, .int_temp, .cell_gate_pin, .open_load_diag_current, .int_overtemp_warn);
  cbd_rr_model #(.PERIOD(16)) cells (.aclk, .run, .diag_on, .rr_tick, .rr_diag_active);
  initial forever #2.5 aclk = ~aclk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard, far above the eight hundred or so cycles needed
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // address and data offered together, each dropped once taken; stall holds off bready
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY,
    input int stall = 0);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (stall == 0);
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    if (stall != 0)
    begin
      repeat (stall) @(posedge aclk);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
    end
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  // stall keeps rready low a few cycles after rvalid so the answer must hold
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
    input logic [1:0] r = RESP_OKAY, input int stall = 0);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (stall == 0);
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    if (stall != 0)
    begin
      repeat (stall) @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
    end
    chk(s_axi_rdata & m, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  task automatic gchk(input logic [11:0] e);
    repeat (2) @(posedge aclk);
    chk({20'h0, cell_gate_pin}, {20'h0, e});
  endtask
  // one result pulse, open-load when sel is high, current otherwise
  task automatic res(input logic sel, input logic [3:0] c, input logic [9:0] v);
    ol_cell <= c;
    cur_cell <= c;
    ol_drop <= v;
    cur_value <= v[7:0];
    ol_valid <= sel;
    cur_valid <= !sel;
    @(posedge aclk);
    ol_valid <= 1'b0;
    cur_valid <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic temp(input logic [9:0] v);
    int_temp <= v;
    temp_valid <= 1'b1;
    @(posedge aclk);
    temp_valid <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic t_regs();
    rdc(OFF_CTRL, CTRL_RST);
    rdc(OFF_OT_THR, {22'h0, OT_THR_RST});
    rdc(8'h40, 32'h0, '1, RESP_SLVERR);
    wr(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
    // a single byte lane must leave the other lanes alone
    s_axi_wstrb <= 4'h1;
    wr(OFF_OL_THR, 32'hFFFF_FF3F);
    s_axi_wstrb <= 4'hF;
    rdc(OFF_OL_THR, 32'h0000_003F);
    wr(OFF_BAL_EN, 32'hFFF);
    gchk(12'hFFF);
    wr(OFF_BAL_EN, 32'h5A3);
    gchk(12'h5A3);
  endtask
  task automatic t_pause();
    wr(OFF_BAL_EN, 32'hFFF);
    wr(OFF_CTRL, CTRL_RST | 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      {primary_cell_volt_meas, secondary_cell_volt_meas, block_volt_meas} <= 3'h4 >> i;
      gchk(12'h0);
      gchk(12'h0);
      {primary_cell_volt_meas, secondary_cell_volt_meas, block_volt_meas} <= 3'h0;
      gchk(12'hFFF);
    end
    wr(OFF_CTRL, CTRL_RST);
    primary_cell_volt_meas <= 1'b1;
    gchk(12'hFFF);
    primary_cell_volt_meas <= 1'b0;
  endtask
  task automatic t_timer();
    wr(OFF_TTHR_LO, 32'h3FFF_FC41);
    wr(OFF_TTHR_HI, 32'h3FFF_FFFF);
    wr(OFF_CTRL, 32'h82);
    wr(OFF_COMM_WATCHDOG, 32'h0);
    gchk(12'hFFF);
    repeat (26) @(posedge aclk);
    gchk(12'hFFE);
    repeat (18) @(posedge aclk);
    gchk(12'hFFC);
    rdc(OFF_COMM_WATCHDOG, 32'h2, 32'h1F);
    wr(OFF_CTRL, CTRL_RST);
  endtask
  task automatic t_pwm();
    logic [31:0] n;
    run <= 1'b1;
    for (int d = 0; d <= 8; d += 2)
    begin
      wr(OFF_CTRL, 32'(d) << CTRL_DUTY_LSB);
      repeat (40) @(posedge aclk);
      n = 0;
      repeat (64)
      begin
        @(posedge aclk);
        n += cell_gate_pin[0];
      end
      chk(n, 32'(d * 8));
    end
    diag_on <= 1'b1;
    n = 0;
    // a switch closed while a sink is on lands in bits 23:12 and spoils the sum
    repeat (64)
    begin
      @(posedge aclk);
      n |= open_load_diag_current;
      if (open_load_diag_current != 12'h000)
        n |= {8'h00, cell_gate_pin, 12'h000};
    end
    chk(n, 32'hFFF);
    run <= 1'b0;
    diag_on <= 1'b0;
  endtask
  task automatic t_diag();
    wr(OFF_OL_THR, 32'h0014_0004);
    res(1'b1, 4'h2, 10'h00A);
    res(1'b1, 4'h4, 10'h002);
    res(1'b1, 4'h6, 10'h01E);
    rdc(OFF_OL_RES, 32'h50);
    rdc(OFF_GENERAL_DIAG_REG, 32'h1, 32'h1);
    wr(OFF_OL_RES, 32'hFFF);
    wr(OFF_OL_THR, 32'h0);
    res(1'b1, 4'h1, 10'h3FB);
    res(1'b1, 4'h3, 10'h03C);
    rdc(OFF_OL_RES, 32'h0);
    wr(OFF_CUR_THR, 32'h000A_0064);
    res(1'b0, 4'h2, 10'h096);
    res(1'b0, 4'h4, 10'h005);
    res(1'b0, 4'h6, 10'h032);
    gchk(12'hFEB);
    rdc(OFF_OC_RES, 32'h4);
    rdc(OFF_UC_RES, 32'h10);
    rdc(OFF_GENERAL_DIAG_REG, 32'h6, 32'h6);
  endtask
  task automatic t_end();
    wr(OFF_OT_THR, 32'h200, RESP_OKAY, 2);
    temp(10'h1FF);
    chk({31'h0, int_overtemp_warn}, 32'h0);
    temp(10'h3FF);
    gchk(12'h0);
    chk({31'h0, int_overtemp_warn}, 32'h1);
    wr(OFF_BAL_EN, 32'h0);
    wr(OFF_CTRL, 32'h0FFF_0084);
    repeat (3) @(posedge aclk);
    chk({20'h0, open_load_diag_current}, 32'hFFF);
    // status is read-only: the write is answered and changes nothing
    wr(OFF_STATUS, 32'hFFFF_FFFF);
    // forced sinks show with every switch open; parity bit masked out
    rdc(OFF_STATUS, 32'h0FFF_0000, 32'h0FFF_0FFF, RESP_OKAY, 2);
  endtask
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_pause();
    t_timer();
    t_pwm();
    t_diag();
    t_end();
    stop_test();
  end
endmodule
